//--- bench/mfd_checker_properties.sv
`timescale 1ns/1ns
module mfd_checker(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic stepDone,
   input wire logic jumpValid,
   input wire logic subroutineJump,
   input wire logic specialEnable,
   input wire logic skipEnable,
   input wire logic haltReq,
   input wire logic stall,
   input wire logic cpuFlag,
   input wire logic overflowFlag,
   input wire logic extendFlag,
   input wire logic [mfd_pkg::DATA_W-1:0] resultHigh
);
   // ------
   // Sequencing and commit checks
   // ------
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);
   chk_jump_step: assert property (jumpValid |-> stepDone)
      else $error("jump pulse without step");
   chk_jump_nop: assert property (jumpValid |=> !stepDone && !jumpValid)
      else $error("no idle cycle after jump");
   chk_sub_jump: assert property (subroutineJump |-> jumpValid)
      else $error("subroutine jump not taken");
   chk_jump_inhibit: assert property (jumpValid |-> !specialEnable && !skipEnable)
      else $error("special or skip live on jump");
   chk_stall_hold: assert property (stall |-> !stepDone)
      else $error("step during stall");
   chk_halt_nojump: assert property ($rose(haltReq) |-> !jumpValid)
      else $error("halt together with jump");
   chk_flag_commit: assert property ($changed({cpuFlag, overflowFlag, extendFlag}) |-> stepDone)
      else $error("flag moved off commit");
   chk_result_commit: assert property ($changed(resultHigh) |-> stepDone)
      else $error("result moved off commit");
endmodule : mfd_checker
bind microword_field_decoder mfd_checker mfd_checker_i (.*);

//--- bench/mfd_mem_model.sv
`timescale 1ns/1ns
module mfd_mem_model(
   input wire logic core_clk,
   input wire logic memGo,
   output logic dataReady,
   output logic [15:0] regT
);
   logic [15:0] junk = 16'h0000;
   // Ready follows the go request one cycle late
   always_ff @(posedge core_clk) begin
      dataReady <= memGo;
      junk <= junk + 16'h0001;
   end
   // Data valid only while ready, else a moving pattern
   assign regT = dataReady ? 16'h5A5A : ~junk;
endmodule : mfd_mem_model

//--- bench/microword_field_decoder_tb.sv
`timescale 1ns/1ns
module microword_field_decoder_tb;
   import mfd_pkg::*;
   logic core_clk = 1'b0, rst_n = 1'b0, memGo = 1'b1, dataReady;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hF, storeCode;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, stepDone, jumpValid;
   logic subroutineJump, specialEnable, skipEnable, cpuFlag, overflowFlag, extendFlag, haltReq, stall;
   logic [15:0] regA = 16'h7000, regB = 16'h1234, regF = 16'h8421, regQ = 16'hC003, regP = 16'hFC00;
   logic [15:0] scratch1 = 16'h0B0B, scratch2 = 16'h0, scratch3 = 16'h0, scratch4 = 16'h0;
   logic [15:0] instrReg = 16'h0E5A, ioBus = 16'h3C3C, regT, resultHigh, resultLow;
   logic [14:0] regM = 15'h6ABC;
   logic [9:0] jumpTarget;
   logic [5:0] intCode = 6'h2D;
   logic [4:0] loopCount = 5'h13;
   logic a_addressable_ff = 1'b0, b_addressable_ff = 1'b0, indexMode = 1'b1, addInstr = 1'b1;
   logic interruptPending = 1'b0, panelHalt = 1'b0;
   int numErrors = 0, nTests = 0, nJumps = 0;
   microword_field_decoder microword_field_decoder_i (.*);
   mfd_mem_model mfd_mem_model_i (.*);
   always #20 core_clk = ~core_clk;
   // Count taken jumps
   always @(posedge core_clk) if (jumpValid === 1'b1) nJumps <= nJumps + 1;
   // ------
   // Bus tasks
   // ------
   task automatic chk(input logic [31:0] g, e);
      nTests++;
      if (g !== e) begin
         numErrors++;
         $display("unexpected %0t: got %h want %h", $time, g, e);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, logic [31:0] d, logic [1:0] r);
      @(posedge core_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge core_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      chk({30'h0, s_axi_bresp}, {30'h0, r});
      s_axi_bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, logic [31:0] e, logic [1:0] r);
      @(posedge core_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge core_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      chk(s_axi_rdata, e);
      chk({30'h0, s_axi_rresp}, {30'h0, r});
      s_axi_rready <= 1'b0;
   endtask : rd
   task automatic mw(input logic [23:0] w);
      wr(OFF_MICROWORD, {8'h00, w}, RESP_OKAY);
      repeat (6) @(posedge core_clk);
   endtask : mw
   task automatic src(input logic [2:0] r, input logic [3:0] s, input logic [7:0] lo, input logic [15:0] eR, eS);
      mw({r, s, F_OR_PASS, 4'hF, lo});
      rd(OFF_RBUS, {16'h0, eR}, RESP_OKAY);
      rd(OFF_SBUS, {16'h0, eS}, RESP_OKAY);
   endtask : src
   task endSim;
      $display("errors %0d checks %0d", numErrors, nTests);
      if (numErrors == 0 && nTests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : endSim
   // Watchdog
   initial begin
      repeat (20000) @(posedge core_clk);
      numErrors++;
      endSim;
   end
   // ------
   // Test sequence
   // ------
   initial begin
      repeat (12) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge core_clk);
      rd(OFF_STATUS, 32'h0, RESP_OKAY);
      rd(OFF_MICROWORD, 32'hFFFFFF, RESP_OKAY);
      src(R_NOP, S_NOP, 8'hFF, 16'h0, 16'h0);
      src(R_IR11_AB, S_CONST_L, 8'hA7, regB, 16'hA700);
      chk({30'h0, specialEnable, skipEnable}, 32'h0);
      src(R_DIAG_Q, S_CONST_R, 8'hA7, regQ, 16'h00A7);
      src(R_A, S_OPER_ADDR, 8'hFF, regA, 16'hFE5A);
      src(R_ADDR_AB, S_INT_CODE, 8'hFF, regA, 16'h002D);
      src(R_F, S_COUNTER, 8'hFF, regF, 16'h0013);
      src(R_B, S_M, 8'hFF, regB, 16'h6ABC);
      src(R_Q, S_R_COPY, 8'hFF, regQ, regQ);
      src(R_NOP, S_IO_IN, 8'hFF, 16'h0, ioBus);
      src(R_A, S_SP1, 8'hFF, regA, scratch1);
      b_addressable_ff <= 1'b1;
      src(R_ADDR_AB, S_PAIR, 8'hFF, regB, regB);
      b_addressable_ff <= 1'b0;
      memGo <= 1'b0;
      wr(OFF_MICROWORD, {8'h00, R_NOP, S_T, F_OR_PASS, 4'hF, 8'hFF}, RESP_OKAY);
      repeat (4) @(negedge core_clk);
      rd(OFF_STATUS, 32'h402, RESP_OKAY);
      memGo <= 1'b1;
      repeat (6) @(negedge core_clk);
      rd(OFF_SBUS, 32'h5A5A, RESP_OKAY);
      mw({R_A, S_NOP, F_ONES_SUB, 4'hF, 8'hFF});
      rd(OFF_RES_HIGH, 32'h6FFF, RESP_OKAY);
      mw({R_F, S_CONST_L, F_ADD_OVF, 4'hF, 8'h80});
      rd(OFF_RES_HIGH, 32'h0421, RESP_OKAY);
      chk({30'h0, overflowFlag, extendFlag}, 32'h3);
      mw({R_A, S_NOP, F_CLR_OVF, 4'h6, 8'hFF});
      chk({27'h0, storeCode, overflowFlag}, 32'hC);
      mw({R_A, S_NOP, F_SET_FLAG, 4'hF, 8'hFF});
      chk({31'h0, cpuFlag}, 32'h1);
      mw({R_A, S_NOP, F_CLR_FLAG, 4'hF, 8'hFF});
      chk({31'h0, cpuFlag}, 32'h0);
      mw({R_F, S_NOP, F_ROT32, 4'hF, SP_LEFT_ONE, SK_NOP});
      rd(OFF_RES_LOW, 32'h8007, RESP_OKAY);
      mw({R_F, S_NOP, F_ASH32, 4'hF, SP_LEFT_ONE, SK_NOP});
      rd(OFF_RES_HIGH, 32'h8843, RESP_OKAY);
      chk({31'h0, overflowFlag}, 32'h1);
      mw({R_B, S_SP1, F_UNDEF, 4'hF, 8'hFF});
      rd(OFF_RES_HIGH, 32'h1B3F, RESP_OKAY);
      mw({R_NOP, S_NOP, F_UJMP0, 4'hF, 8'h35});
      rd(OFF_JUMP, 32'h135, RESP_OKAY);
      mw({R_NOP, S_NOP, F_USUB_JMP0, 4'hF, 8'h35});
      chk(nJumps, 32'd2);
      wr(OFF_CONTROL, 32'h1, RESP_OKAY);
      mw({R_NOP, S_NOP, F_CJMP0, 4'hF, 8'h0E});
      chk({31'h0, haltReq}, 32'h1);
      wr(OFF_CONTROL, 32'h0, RESP_OKAY);
      mw({R_NOP, S_NOP, F_CJMP0, 4'hF, 8'h0E});
      interruptPending <= 1'b1;
      mw({R_NOP, S_NOP, F_CJMP1, 4'hF, 8'h0E});
      chk(nJumps, 32'd3);
      rd(8'h20, 32'h0, RESP_SLVERR);
      wr(OFF_STATUS, 32'hFFFF, RESP_SLVERR);
      endSim;
   end
endmodule : microword_field_decoder_tb

//--- verilog/mfd_alu_shift.sv
`timescale 1ns/1ns
module mfd_alu_shift
   import mfd_pkg::*;
(
   input wire logic [4:0] fnCode,
   input wire logic [3:0] specialCode,
   input wire logic [DATA_W-1:0] rBus,
   input wire logic [DATA_W-1:0] sBus,
   input wire logic [DATA_W-1:0] lowIn,
   input wire logic addInstr,
   output logic [DATA_W-1:0] highOut,
   output logic [DATA_W-1:0] lowOut,
   output logic ovfSet,
   output logic extSet
);
   logic [DATA_W:0] sum;
   logic [DATA_W-1:0] orv;
   logic left;
   logic right;

   // Function unit with 32-bit shift paths
   always_comb begin
      sum = {1'b0, rBus} + {1'b0, sBus};
      orv = rBus | sBus;
      left = (specialCode == SP_LEFT_ONE);
      right = (specialCode == SP_RIGHT_ONE);
      highOut = orv;
      lowOut = lowIn;
      ovfSet = 1'b0;
      extSet = 1'b0;
      unique case (fnCode)
         F_ADD: highOut = sum[DATA_W-1:0];
         F_ADD_OVF: begin
            highOut = sum[DATA_W-1:0];
            ovfSet = (rBus[15] == sBus[15]) && (sum[15] != rBus[15]);
            extSet = addInstr && sum[DATA_W];
         end
         F_ONES_SUB: highOut = rBus + ~sBus;
         F_ASH32: begin
            if (left) begin
               highOut = {orv[15], orv[13:0], lowIn[15]};
               lowOut = {lowIn[14:0], 1'b0};
               ovfSet = orv[15] ^ orv[14];
            end else if (right) begin
               highOut = {orv[15], orv[15], orv[14:1]};
               lowOut = {orv[0], lowIn[15:1]};
            end
         end
         F_ROT32: begin
            if (left) begin
               highOut = {orv[14:0], lowIn[15]};
               lowOut = {lowIn[14:0], orv[15]};
            end else if (right) begin
               highOut = {lowIn[0], orv[15:1]};
               lowOut = {orv[0], lowIn[15:1]};
            end
         end
         default: highOut = orv;
      endcase
   end
endmodule : mfd_alu_shift

//--- verilog/mfd_pkg.sv
package mfd_pkg;
   // ----------------------------------------
   // Microword layout
   // ----------------------------------------
   localparam int MW_WIDTH = 24;
   localparam int SKIP_LSB = 0;
   localparam int SPEC_LSB = 4;
   localparam int STORE_LSB = 8;
   localparam int FUNC_LSB = 12;
   localparam int SBUS_LSB = 17;
   localparam int RBUS_LSB = 21;
   localparam int DATA_W = 16;

   // ----------------------------------------
   // Field codes
   // ----------------------------------------
   localparam logic [2:0] R_A = 3'h0, R_B = 3'h1, R_Q = 3'h2, R_F = 3'h3;
   localparam logic [2:0] R_IR11_AB = 3'h4, R_ADDR_AB = 3'h5, R_DIAG_Q = 3'h6, R_NOP = 3'h7;
   localparam logic [3:0] S_INT_CODE = 4'h0, S_IO_IN = 4'h1, S_T = 4'h2, S_M = 4'h3;
   localparam logic [3:0] S_R_COPY = 4'h4, S_COUNTER = 4'h5, S_OPER_ADDR = 4'h6, S_PAIR = 4'h7;
   localparam logic [3:0] S_SP4 = 4'h8, S_SP3 = 4'h9, S_SP2 = 4'hA, S_SP1 = 4'hB;
   localparam logic [3:0] S_CONST_R = 4'hC, S_CONST_L = 4'hD, S_P = 4'hE, S_NOP = 4'hF;
   localparam logic [4:0] F_ONES_SUB = 5'h06, F_UNDEF = 5'h07, F_ADD_OVF = 5'h0A, F_ADD = 5'h0B;
   localparam logic [4:0] F_USUB_JMP0 = 5'h10, F_USUB_JMP1 = 5'h11, F_UJMP0 = 5'h12, F_UJMP1 = 5'h13;
   localparam logic [4:0] F_CJMP0 = 5'h14, F_ROT32 = 5'h17, F_ASH32 = 5'h18, F_CJMP1 = 5'h19;
   localparam logic [4:0] F_CLR_FLAG = 5'h1B, F_SET_FLAG = 5'h1C, F_CLR_OVF = 5'h1D;
   localparam logic [4:0] F_SET_OVF = 5'h1E, F_OR_PASS = 5'h1F;
   localparam logic [3:0] SP_LEFT_ONE = 4'h1, SP_RIGHT_ONE = 4'h2, SP_NOP = 4'hF, SK_NOP = 4'hF;
   localparam logic [7:0] BYTE_ZERO = 8'h00;

   // ----------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] OFF_MICROWORD = 8'h00, OFF_CONTROL = 8'h04, OFF_STATUS = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_RBUS = 8'h0C, OFF_SBUS = 8'h10, OFF_RES_HIGH = 8'h14;
   localparam logic [ADDR_W-1:0] OFF_RES_LOW = 8'h18, OFF_JUMP = 8'h1C;
   localparam logic [1:0] RESP_OKAY = 2'h0, RESP_SLVERR = 2'h2;
   localparam int CTRL_SINGLE = 0;
   localparam logic [MW_WIDTH-1:0] MW_RESET = 24'hFFFFFF;

   // ----------------------------------------
   // Sequencer states
   // ----------------------------------------
   typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_EXEC = 2'h1, ST_JUMP_NOP = 2'h3} mfd_state_t;
endpackage : mfd_pkg

//--- verilog/mfd_source_select.sv
`timescale 1ns/1ns
module mfd_source_select
   import mfd_pkg::*;
(
   input wire logic [2:0] rCode,
   input wire logic [3:0] sCode,
   input wire logic [7:0] constByte,
   input wire logic inhibitReadP,
   input wire logic [DATA_W-1:0] regA,
   input wire logic [DATA_W-1:0] regB,
   input wire logic [DATA_W-1:0] regF,
   input wire logic [DATA_W-1:0] regQ,
   input wire logic [DATA_W-1:0] regT,
   input wire logic [DATA_W-1:0] regP,
   input wire logic [14:0] regM,
   input wire logic [DATA_W-1:0] scratch1,
   input wire logic [DATA_W-1:0] scratch2,
   input wire logic [DATA_W-1:0] scratch3,
   input wire logic [DATA_W-1:0] scratch4,
   input wire logic [DATA_W-1:0] instrReg,
   input wire logic [5:0] intCode,
   input wire logic [4:0] loopCount,
   input wire logic [DATA_W-1:0] ioBus,
   input wire logic aAddrFf,
   input wire logic bAddrFf,
   input wire logic indexMode,
   output logic [DATA_W-1:0] rBus,
   output logic [DATA_W-1:0] sBus
);
   // R-bus source
   always_comb begin
      unique case (rCode)
         R_A: rBus = regA;
         R_B: rBus = regB;
         R_Q: rBus = regQ;
         R_F: rBus = regF;
         R_IR11_AB: rBus = instrReg[11] ? regB : regA;
         R_ADDR_AB: rBus = bAddrFf ? regB : regA;
         R_DIAG_Q: rBus = (instrReg[9] && indexMode) ? regQ : '0;
         R_NOP: rBus = '0;
      endcase
   end

   // S-bus source
   always_comb begin
      unique case (sCode)
         S_INT_CODE: sBus = {10'h000, intCode};
         S_IO_IN: sBus = ioBus;
         S_T: sBus = regT;
         S_M: sBus = {1'b0, regM};
         S_R_COPY: sBus = rBus;
         S_COUNTER: sBus = {11'h000, loopCount};
         S_OPER_ADDR: sBus = {instrReg[10] ? regP[15:10] : 6'h00, instrReg[9:0]};
         S_PAIR: sBus = (aAddrFf || bAddrFf) ? rBus : regT;
         S_SP4: sBus = scratch4;
         S_SP3: sBus = scratch3;
         S_SP2: sBus = scratch2;
         S_SP1: sBus = scratch1;
         S_CONST_R: sBus = {BYTE_ZERO, constByte};
         S_CONST_L: sBus = {constByte, BYTE_ZERO};
         S_P: sBus = inhibitReadP ? '0 : regP;
         S_NOP: sBus = '0;
      endcase
   end
endmodule : mfd_source_select

//--- verilog/microword_field_decoder.sv
// The register addresses and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ns
// Summary of operation
// - Constant sources take microword bits 0-7 as the constant value.
// - Constant sources or jump functions suppress special and skip fields.
// - R field uses 3 bits, function 5, all other fields 4.
// - Addressable source picks A or B by flip-flops; neither gives A.
// - Instruction bit 11 picks A (zero) or B (one) on R-bus.
// - Diagnostic source gives Q only with instruction bit 9 and index mode.
// - No-operation codes drive zeros on R-bus and S-bus.
// - Operand address: instruction bits 0-9, upper bits from P if bit 10.
// - Interrupt code lands on S-bus bits 0-5.
// - Left constant on bits 8-15, right constant on bits 0-7, rest zero.
// - Loop counter lands on S-bus bits 0-4, bit 0 least significant.
// - Pair read puts chosen register on both buses, else T on S-bus.
// - T or pair read stalls until memory data ready.
// - Memory address register is 15 bits; top S-bus bit stays zero.
// - R-to-S copy and IO input sources feed the S-bus.
// - Overflow add detects overflow; extend enabled for add-to-A/B instructions.
// - Arithmetic 32-bit shift keeps sign, overflow on bits 14/15 differing.
// - Conditional jump on interrupt or halt in run, halts in single-cycle.
// - Rotate moves high bit 15 to low bit 0, or back.
// - One's complement subtract; zero S-bus decrements R-bus.
// - Flag and overflow clear functions clear their flip-flops, OR pass.
// - Jump target from bits 0-7, 17, 12, S-bus bits 0-3 ORed.
// - Every taken jump takes two cycles, second an inserted no-operation.
// - Microword is 24 bits in six fields.
module microword_field_decoder
   import mfd_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [mfd_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [mfd_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   input wire logic [mfd_pkg::DATA_W-1:0] regA,
   input wire logic [mfd_pkg::DATA_W-1:0] regB,
   input wire logic [mfd_pkg::DATA_W-1:0] regF,
   input wire logic [mfd_pkg::DATA_W-1:0] regQ,
   input wire logic [mfd_pkg::DATA_W-1:0] regT,
   input wire logic [mfd_pkg::DATA_W-1:0] regP,
   input wire logic [14:0] regM,
   input wire logic [mfd_pkg::DATA_W-1:0] scratch1,
   input wire logic [mfd_pkg::DATA_W-1:0] scratch2,
   input wire logic [mfd_pkg::DATA_W-1:0] scratch3,
   input wire logic [mfd_pkg::DATA_W-1:0] scratch4,
   input wire logic [mfd_pkg::DATA_W-1:0] instrReg,
   input wire logic [5:0] intCode,
   input wire logic [4:0] loopCount,
   input wire logic [mfd_pkg::DATA_W-1:0] ioBus,
   input wire logic a_addressable_ff,
   input wire logic b_addressable_ff,
   input wire logic indexMode,
   input wire logic addInstr,
   input wire logic dataReady,
   input wire logic interruptPending,
   input wire logic panelHalt,
   output logic [mfd_pkg::DATA_W-1:0] resultHigh,
   output logic [mfd_pkg::DATA_W-1:0] resultLow,
   output logic [3:0] storeCode,
   output logic stepDone,
   output logic [9:0] jumpTarget,
   output logic jumpValid,
   output logic subroutineJump,
   output logic specialEnable,
   output logic skipEnable,
   output logic cpuFlag,
   output logic overflowFlag,
   output logic extendFlag,
   output logic haltReq,
   output logic stall
);
   import mfd_pkg::*;

   // --------------------------------------------------
   // Field extraction and decode
   // --------------------------------------------------
   logic [MW_WIDTH-1:0] microword_hold_reg;
   logic singleCycle;
   mfd_state_t state;
   logic [2:0] rCode;
   logic [3:0] sCode;
   logic [4:0] fnCode;
   logic [3:0] stCode;
   logic [3:0] spCode;
   logic [3:0] skCode;
   logic isJump;
   logic isCondJump;
   logic isSubJump;
   logic isConst;
   logic inhibitSpecSkip;
   logic needData;
   logic stallNow;
   logic commit;
   logic jumpGo;
   logic [DATA_W-1:0] rBus;
   logic [DATA_W-1:0] sBus;
   logic [DATA_W-1:0] lowIn;
   logic [DATA_W-1:0] aluHigh;
   logic [DATA_W-1:0] aluLow;
   logic aluOvf;
   logic aluExt;
   logic [9:0] next_jumpTarget;
   logic [DATA_W-1:0] rBusHold;
   logic [DATA_W-1:0] sBusHold;

   // Jump function codes carry two encodings each
   function automatic logic fn_is_jump(input logic [4:0] fn);
      fn_is_jump = (fn == F_UJMP0) || (fn == F_UJMP1) || (fn == F_USUB_JMP0) || (fn == F_USUB_JMP1)
         || (fn == F_CJMP0) || (fn == F_CJMP1);
   endfunction : fn_is_jump

   // Field slices of the held microword
   assign rCode = microword_hold_reg[RBUS_LSB +: 3];
   assign sCode = microword_hold_reg[SBUS_LSB +: 4];
   assign fnCode = microword_hold_reg[FUNC_LSB +: 5];
   assign stCode = microword_hold_reg[STORE_LSB +: 4];
   assign spCode = microword_hold_reg[SPEC_LSB +: 4];
   assign skCode = microword_hold_reg[SKIP_LSB +: 4];

   // Suppression, stall and jump qualification
   assign isJump = fn_is_jump(fnCode);
   assign isCondJump = (fnCode == F_CJMP0) || (fnCode == F_CJMP1);
   assign isSubJump = (fnCode == F_USUB_JMP0) || (fnCode == F_USUB_JMP1);
   assign isConst = (sCode == S_CONST_L) || (sCode == S_CONST_R);
   assign inhibitSpecSkip = isConst || isJump;
   assign needData = (sCode == S_T) || (sCode == S_PAIR);
   assign stallNow = (state == ST_EXEC) && needData && !dataReady;
   assign commit = (state == ST_EXEC) && !stallNow;
   assign jumpGo = isJump && (!isCondJump || (!singleCycle && (interruptPending || panelHalt)));
   assign lowIn = (microword_hold_reg[SPEC_LSB +: 4] == SP_LEFT_ONE) ? regQ : regA;
   assign next_jumpTarget = {microword_hold_reg[FUNC_LSB], microword_hold_reg[SBUS_LSB],
      microword_hold_reg[SPEC_LSB +: 4], microword_hold_reg[SKIP_LSB +: 4] | sBus[3:0]};

   // --------------------------------------------------
   // Datapath sources and function unit
   // --------------------------------------------------
   mfd_source_select u_src (
      .rCode(rCode),
      .sCode(sCode),
      .constByte(microword_hold_reg[7:0]),
      .inhibitReadP(isJump),
      .regA(regA),
      .regB(regB),
      .regF(regF),
      .regQ(regQ),
      .regT(regT),
      .regP(regP),
      .regM(regM),
      .scratch1(scratch1),
      .scratch2(scratch2),
      .scratch3(scratch3),
      .scratch4(scratch4),
      .instrReg(instrReg),
      .intCode(intCode),
      .loopCount(loopCount),
      .ioBus(ioBus),
      .aAddrFf(a_addressable_ff),
      .bAddrFf(b_addressable_ff),
      .indexMode(indexMode),
      .rBus(rBus),
      .sBus(sBus)
   );

   mfd_alu_shift u_alu (
      .fnCode(fnCode),
      .specialCode(spCode),
      .rBus(rBus),
      .sBus(sBus),
      .lowIn(lowIn),
      .addInstr(addInstr),
      .highOut(aluHigh),
      .lowOut(aluLow),
      .ovfSet(aluOvf),
      .extSet(aluExt)
   );

   // --------------------------------------------------
   // AXI4-Lite slave
   // --------------------------------------------------
   logic awHeld;
   logic wHeld;
   logic [ADDR_W-1:0] awAddr;
   logic [31:0] wData;
   logic [3:0] wStrb;
   logic doWrite;
   logic mwWrite;

   assign doWrite = awHeld && wHeld && !s_axi_bvalid;
   assign mwWrite = doWrite && (awAddr == OFF_MICROWORD) && (state == ST_IDLE);

   // Write address and data capture, either order
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         awHeld <= 1'b0;
         wHeld <= 1'b0;
         awAddr <= '0;
         wData <= '0;
         wStrb <= '0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld <= 1'b1;
            awAddr <= s_axi_awaddr;
         end else if (doWrite) begin
            awHeld <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld <= 1'b1;
            wData <= s_axi_wdata;
            wStrb <= s_axi_wstrb;
         end else if (doWrite) begin
            wHeld <= 1'b0;
         end
      end
   end

   // Ready strobes and write response
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else begin
         s_axi_awready <= !awHeld && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
         s_axi_wready <= !wHeld && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
         if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            if (awAddr == OFF_CONTROL || mwWrite) begin
               s_axi_bresp <= RESP_OKAY;
            end else begin
               s_axi_bresp <= RESP_SLVERR; // Busy microword or read-only/unmapped
            end
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Software registers
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         microword_hold_reg <= MW_RESET;
         singleCycle <= 1'b0;
      end else if (doWrite) begin
         if (mwWrite) begin
            for (int i = 0; i < 3; i++) begin
               if (wStrb[i]) begin
                  microword_hold_reg[i*8 +: 8] <= wData[i*8 +: 8];
               end
            end
         end
         if (awAddr == OFF_CONTROL && wStrb[0]) begin
            singleCycle <= wData[CTRL_SINGLE];
         end
      end
   end

   // Read channel
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            unique case (s_axi_araddr)
               OFF_MICROWORD: s_axi_rdata <= {8'h00, microword_hold_reg};
               OFF_CONTROL: s_axi_rdata <= {31'h00000000, singleCycle};
               OFF_STATUS: s_axi_rdata <= {20'h00000, state, subroutineJump, jumpValid, skipEnable,
                  specialEnable, haltReq, extendFlag, overflowFlag, cpuFlag, stall, stepDone};
               OFF_RBUS: s_axi_rdata <= {16'h0000, rBusHold};
               OFF_SBUS: s_axi_rdata <= {16'h0000, sBusHold};
               OFF_RES_HIGH: s_axi_rdata <= {16'h0000, resultHigh};
               OFF_RES_LOW: s_axi_rdata <= {16'h0000, resultLow};
               OFF_JUMP: s_axi_rdata <= {22'h000000, jumpTarget};
               default: begin
                  s_axi_rdata <= '0;
                  s_axi_rresp <= RESP_SLVERR;
               end
            endcase
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // --------------------------------------------------
   // Step sequencer
   // --------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_IDLE;
      end else begin
         unique case (state)
            ST_IDLE: if (mwWrite) state <= ST_EXEC;
            ST_EXEC: if (commit) state <= jumpGo ? ST_JUMP_NOP : ST_IDLE;
            ST_JUMP_NOP: state <= ST_IDLE;
         endcase
      end
   end

   // Committed results and pulses
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         resultHigh <= '0;
         resultLow <= '0;
         rBusHold <= '0;
         sBusHold <= '0;
         storeCode <= SP_NOP;
         specialEnable <= 1'b0;
         skipEnable <= 1'b0;
         stepDone <= 1'b0;
         jumpValid <= 1'b0;
         subroutineJump <= 1'b0;
         jumpTarget <= '0;
         stall <= 1'b0;
      end else begin
         stall <= stallNow;
         stepDone <= commit;
         jumpValid <= commit && jumpGo;
         subroutineJump <= commit && isSubJump;
         if (commit) begin
            resultHigh <= aluHigh;
            resultLow <= aluLow;
            rBusHold <= rBus;
            sBusHold <= sBus;
            storeCode <= stCode;
            specialEnable <= !inhibitSpecSkip && (spCode != SP_NOP);
            skipEnable <= !inhibitSpecSkip && (skCode != SK_NOP);
            jumpTarget <= next_jumpTarget;
         end else if (state == ST_JUMP_NOP) begin
            storeCode <= SP_NOP;
            specialEnable <= 1'b0;
            skipEnable <= 1'b0;
         end
      end
   end

   // Processor flags, changed at commit by flag functions, overflow add and arithmetic shift; halt request cleared by microword write
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cpuFlag <= 1'b0;
         overflowFlag <= 1'b0;
         extendFlag <= 1'b0;
         haltReq <= 1'b0;
      end else begin
         if (commit) begin
            if (fnCode == F_CLR_FLAG) cpuFlag <= 1'b0;
            if (fnCode == F_SET_FLAG) cpuFlag <= 1'b1;
            if (fnCode == F_CLR_OVF) overflowFlag <= 1'b0;
            else if (fnCode == F_SET_OVF || aluOvf) overflowFlag <= 1'b1;
            if (aluExt) extendFlag <= 1'b1;
            if (isCondJump && singleCycle) haltReq <= 1'b1;
         end else if (mwWrite) begin
            haltReq <= 1'b0;
         end
      end
   end
endmodule : microword_field_decoder
